// >>> core/stm_timer.sv
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module stm_timer (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // Register port
    input wire logic [2:0] reg_addr_in,
    input wire logic [7:0] reg_wr_data_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rd_data_out,
    // Pins
    input wire logic external_count_pin_in,
    input wire logic sub_clock_in,
    input wire logic capture_input_pin_in,
    output logic timer_output_pin_out,
    output logic timer_output_pin_oe_out,
    // Status
    output logic compare_a_flag_out,
    output logic compare_p_flag_out
);
    logic [7:0] ctl0_reg;
    logic [7:0] ctl1_reg;
    logic [15:0] cnt_reg;
    logic [15:0] cmpa_reg;
    logic [7:0] cmpp_reg;
    logic [7:0] byte_buf_reg;
    logic on_prev_reg;
    logic [5:0] presc_reg;
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic [2:0] prev_reg;
    logic level_reg;
    logic [7:0] rd_data_next;

    function automatic logic presc_tick(input logic [5:0] cnt, input logic [5:0] mask);
        presc_tick = (cnt & mask) == mask;
    endfunction

    stm_pkg::stm_mode_e mode;
    logic [1:0] pin_fn;
    logic on_bit, pause, init_level, polarity, swap, clear_sel;
    logic on_rise, count_tick, tick_run;
    logic [15:0] inc;
    logic match_a, match_p, clear_hit, cap_event;
    logic wr_ctl0, wr_flags, rd_cnt_hi, rd_cmpa_hi, wr_cmpa_lo, wr_cmpa_hi;
    logic [16:0] pval, aval, period, duty;
    logic pwm_active, act, pin_next, oe_next, single_end;
    logic ext_rise, ext_fall, sub_rise, cap_rise, cap_fall;

    assign mode = stm_pkg::stm_mode_e'(ctl1_reg[stm_pkg::MODE_MSB:stm_pkg::MODE_LSB]);
    assign pin_fn = ctl1_reg[stm_pkg::PINFN_MSB:stm_pkg::PINFN_LSB];
    assign on_bit = ctl0_reg[stm_pkg::ON_BIT];
    assign pause = ctl0_reg[stm_pkg::PAUSE_BIT];
    assign init_level = ctl1_reg[stm_pkg::INIT_LEVEL_BIT];
    assign polarity = ctl1_reg[stm_pkg::POLARITY_BIT];
    assign swap = ctl1_reg[stm_pkg::SWAP_BIT];
    assign clear_sel = ctl1_reg[stm_pkg::CLEAR_SEL_BIT];
    assign on_rise = on_bit && !on_prev_reg;

    assign wr_ctl0 = reg_wr_in && reg_addr_in == stm_pkg::ADDR_CTL0;
    assign wr_flags = reg_wr_in && reg_addr_in == stm_pkg::ADDR_FLAGS;
    assign wr_cmpa_lo = reg_wr_in && reg_addr_in == stm_pkg::ADDR_CMPA_LO;
    assign wr_cmpa_hi = reg_wr_in && reg_addr_in == stm_pkg::ADDR_CMPA_HI;
    assign rd_cnt_hi = reg_rd_in && reg_addr_in == stm_pkg::ADDR_CNT_HI;
    assign rd_cmpa_hi = reg_rd_in && reg_addr_in == stm_pkg::ADDR_CMPA_HI;

    // Pin inputs pass two flip-flops; the third stage only feeds edge detection.
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
            prev_reg <= 3'h0;
        end else begin
            sync1_reg <= {capture_input_pin_in, sub_clock_in, external_count_pin_in};
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    assign ext_rise = sync2_reg[0] && !prev_reg[0];
    assign ext_fall = !sync2_reg[0] && prev_reg[0];
    assign sub_rise = sync2_reg[1] && !prev_reg[1];
    assign cap_rise = sync2_reg[2] && !prev_reg[2];
    assign cap_fall = !sync2_reg[2] && prev_reg[2];

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            presc_reg <= 6'h00;
        end else begin
            presc_reg <= presc_reg + 6'h01;
        end
    end

    always_comb begin
        unique case (stm_pkg::stm_clk_e'(ctl0_reg[stm_pkg::CLKSEL_MSB:stm_pkg::CLKSEL_LSB]))
            stm_pkg::STM_CLK_SYS_DIV4: count_tick = presc_tick(presc_reg, stm_pkg::DIV4_MASK);
            stm_pkg::STM_CLK_SYS: count_tick = 1'b1;
            stm_pkg::STM_CLK_HIGH_DIV16: count_tick = presc_tick(presc_reg, stm_pkg::DIV16_MASK);
            stm_pkg::STM_CLK_HIGH_DIV64: count_tick = presc_tick(presc_reg, stm_pkg::DIV64_MASK);
            stm_pkg::STM_CLK_SUB: count_tick = sub_rise;
            stm_pkg::STM_CLK_HIGH_DIV8: count_tick = presc_tick(presc_reg, stm_pkg::DIV8_MASK);
            stm_pkg::STM_CLK_PIN_RISE: count_tick = ext_rise;
            stm_pkg::STM_CLK_PIN_FALL: count_tick = ext_fall;
        endcase
    end

    // Pause and off gate the count clock.
    assign tick_run = on_bit && !on_rise && !pause && count_tick;
    assign inc = cnt_reg + stm_pkg::WORD_ONE;
    assign match_a = tick_run && mode != stm_pkg::STM_MODE_CAPTURE && inc == cmpa_reg;
    // P compares the upper byte; zero matches at overflow.
    assign match_p = tick_run && inc[15:8] == cmpp_reg && inc[7:0] == stm_pkg::BYTE_RESET;

    // Clear source; PWM and capture ignore clear select.
    always_comb begin
        unique case (mode)
            stm_pkg::STM_MODE_COMPARE, stm_pkg::STM_MODE_TIMER: begin
                clear_hit = clear_sel ? match_a : match_p;
            end
            stm_pkg::STM_MODE_PWM: begin
                clear_hit = swap ? match_a : match_p;
            end
            stm_pkg::STM_MODE_CAPTURE: begin
                clear_hit = match_p;
            end
        endcase
    end

    always_comb begin
        unique case (pin_fn)
            stm_pkg::PIN_CODE_0: cap_event = cap_rise;
            stm_pkg::PIN_CODE_1: cap_event = cap_fall;
            stm_pkg::PIN_CODE_2: cap_event = cap_rise || cap_fall;
            stm_pkg::PIN_CODE_3: cap_event = 1'b0;
        endcase
    end

    assign single_end = mode == stm_pkg::STM_MODE_PWM && pin_fn == stm_pkg::PIN_CODE_3 && match_a;

    // Low control bits are not stored.
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ctl0_reg <= stm_pkg::BYTE_RESET;
        end else if (wr_ctl0) begin
            ctl0_reg <= reg_wr_data_in & stm_pkg::CTL0_WRITE_MASK;
        end else if (single_end) begin
            ctl0_reg[stm_pkg::ON_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ctl1_reg <= stm_pkg::BYTE_RESET;
            cmpp_reg <= stm_pkg::BYTE_RESET;
        end else if (reg_wr_in) begin
            if (reg_addr_in == stm_pkg::ADDR_CTL1) begin
                ctl1_reg <= reg_wr_data_in;
            end
            if (reg_addr_in == stm_pkg::ADDR_CMPP) begin
                cmpp_reg <= reg_wr_data_in;
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            on_prev_reg <= 1'b0;
        end else begin
            on_prev_reg <= on_bit;
        end
    end

    // Start clears the counter; stop keeps it; one step per tick.
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cnt_reg <= stm_pkg::WORD_RESET;
        end else if (on_rise) begin
            cnt_reg <= stm_pkg::WORD_RESET;
        end else if (tick_run) begin
            cnt_reg <= clear_hit ? stm_pkg::WORD_RESET : inc;
        end
    end

    // Compare A pair; high byte write moves the buffered low byte.
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cmpa_reg <= stm_pkg::WORD_RESET;
        end else if (mode == stm_pkg::STM_MODE_CAPTURE && on_bit && cap_event) begin
            cmpa_reg <= cnt_reg;
        end else if (wr_cmpa_hi) begin
            cmpa_reg <= {reg_wr_data_in, byte_buf_reg};
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            byte_buf_reg <= stm_pkg::BYTE_RESET;
        end else if (wr_cmpa_lo) begin
            byte_buf_reg <= reg_wr_data_in;
        end else if (rd_cnt_hi) begin
            byte_buf_reg <= cnt_reg[7:0];
        end else if (rd_cmpa_hi) begin
            byte_buf_reg <= cmpa_reg[7:0];
        end
    end

    // Separate flags; set wins over a software clear.
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            compare_a_flag_out <= 1'b0;
            compare_p_flag_out <= 1'b0;
        end else begin
            if (match_a || (mode == stm_pkg::STM_MODE_CAPTURE && on_bit && cap_event)) begin
                compare_a_flag_out <= 1'b1;
            end else if (wr_flags && reg_wr_data_in[stm_pkg::FLAG_A_BIT]) begin
                compare_a_flag_out <= 1'b0;
            end
            if (match_p && !(clear_sel && (mode == stm_pkg::STM_MODE_COMPARE ||
                                           mode == stm_pkg::STM_MODE_TIMER))) begin
                compare_p_flag_out <= 1'b1;
            end else if (wr_flags && reg_wr_data_in[stm_pkg::FLAG_P_BIT]) begin
                compare_p_flag_out <= 1'b0;
            end
        end
    end

    // Start restores the initial level; A match acts; same level holds.
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            level_reg <= 1'b0;
        end else if (mode == stm_pkg::STM_MODE_COMPARE) begin
            if (on_rise) begin
                level_reg <= init_level;
            end else if (match_a) begin
                unique case (pin_fn)
                    stm_pkg::PIN_CODE_0: level_reg <= level_reg;
                    stm_pkg::PIN_CODE_1: level_reg <= 1'b0;
                    stm_pkg::PIN_CODE_2: level_reg <= 1'b1;
                    stm_pkg::PIN_CODE_3: level_reg <= !level_reg;
                endcase
            end
        end
    end

    // Period and duty roles; duty at or over period stays active.
    assign pval = (cmpp_reg == stm_pkg::BYTE_RESET) ? stm_pkg::FULL_PERIOD :
                  {1'b0, cmpp_reg, stm_pkg::BYTE_RESET};
    assign aval = {1'b0, cmpa_reg};
    assign period = swap ? aval : pval;
    assign duty = swap ? pval : aval;
    assign pwm_active = (duty >= period) || ({1'b0, cnt_reg} < duty);

    // PWM pin functions; active level; polarity; timer undriven.
    always_comb begin
        unique case (pin_fn)
            stm_pkg::PIN_CODE_0: act = 1'b0;
            stm_pkg::PIN_CODE_1: act = 1'b1;
            stm_pkg::PIN_CODE_2: act = on_bit && pwm_active;
            stm_pkg::PIN_CODE_3: act = on_bit;
        endcase
        pin_next = 1'b0;
        oe_next = 1'b0;
        if (mode == stm_pkg::STM_MODE_COMPARE) begin
            pin_next = level_reg ^ polarity;
            oe_next = 1'b1;
        end else if (mode == stm_pkg::STM_MODE_PWM) begin
            pin_next = (act ? init_level : !init_level) ^ polarity;
            oe_next = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            timer_output_pin_out <= 1'b0;
            timer_output_pin_oe_out <= 1'b0;
        end else begin
            timer_output_pin_out <= pin_next;
            timer_output_pin_oe_out <= oe_next;
        end
    end

    // Counter bytes; low bytes read through the buffer.
    always_comb begin
        rd_data_next = stm_pkg::BYTE_RESET;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                stm_pkg::ADDR_CTL0: rd_data_next = ctl0_reg;
                stm_pkg::ADDR_CTL1: rd_data_next = ctl1_reg;
                stm_pkg::ADDR_CNT_LO: rd_data_next = byte_buf_reg;
                stm_pkg::ADDR_CNT_HI: rd_data_next = cnt_reg[15:8];
                stm_pkg::ADDR_CMPA_LO: rd_data_next = byte_buf_reg;
                stm_pkg::ADDR_CMPA_HI: rd_data_next = cmpa_reg[15:8];
                stm_pkg::ADDR_CMPP: rd_data_next = cmpp_reg;
                stm_pkg::ADDR_FLAGS: begin
                    rd_data_next = {6'h00, compare_p_flag_out, compare_a_flag_out};
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            reg_rd_data_out <= stm_pkg::BYTE_RESET;
        end else begin
            reg_rd_data_out <= rd_data_next;
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);

    pause_hold_a: assert property (pause && !on_rise |=> cnt_reg == $past(cnt_reg))
        else $error("Counter moved while paused.");
    start_clear_a: assert property (on_rise |=> cnt_reg == stm_pkg::WORD_RESET)
        else $error("Counter not cleared at start.");
    stop_keep_a: assert property (!on_bit |=> $stable(cnt_reg))
        else $error("Counter changed while off.");
    init_level_a: assert property (on_rise && mode == stm_pkg::STM_MODE_COMPARE
        |=> level_reg == $past(init_level))
        else $error("Initial level not restored.");
    timer_undriven_a: assert property (mode == stm_pkg::STM_MODE_TIMER
        && $past(mode) == stm_pkg::STM_MODE_TIMER |-> !timer_output_pin_oe_out)
        else $error("Pin driven in timer mode.");
    a_clear_a: assert property (clear_sel && mode == stm_pkg::STM_MODE_COMPARE
        && match_a && !on_rise |=> cnt_reg == stm_pkg::WORD_RESET)
        else $error("A match did not clear counter.");
    no_pflag_a: assert property (mode == stm_pkg::STM_MODE_COMPARE && clear_sel
        && !compare_p_flag_out |=> !compare_p_flag_out)
        else $error("P flag raised under A clear.");
    step_one_a: assert property (tick_run && !clear_hit
        |=> cnt_reg == $past(cnt_reg) + stm_pkg::WORD_ONE)
        else $error("Counter did not step by one.");
    zero_bits_a: assert property (reg_rd_in && reg_addr_in == stm_pkg::ADDR_CTL0
        |=> reg_rd_data_out[2:0] == 3'h0)
        else $error("Unused control bits read nonzero.");
    full_duty_a: assert property (mode == stm_pkg::STM_MODE_PWM
        && pin_fn == stm_pkg::PIN_CODE_2 && on_bit && duty >= period
        |=> timer_output_pin_out == ($past(init_level) ^ $past(polarity)))
        else $error("Full duty not held active.");
    a_flag_set_a: assert property (match_a |=> compare_a_flag_out)
        else $error("A match did not raise its flag.");
    p_flag_set_a: assert property (match_p && mode == stm_pkg::STM_MODE_PWM
        |=> compare_p_flag_out)
        else $error("P match did not raise its flag.");
    rd_idle_a: assert property (!reg_rd_in
        |=> reg_rd_data_out == stm_pkg::BYTE_RESET)
        else $error("Read data not idle.");
    lo_buffer_a: assert property (wr_cmpa_lo && mode != stm_pkg::STM_MODE_CAPTURE
        |=> $stable(cmpa_reg))
        else $error("Low byte write reached compare A.");
    hi_commit_a: assert property (wr_cmpa_hi && mode != stm_pkg::STM_MODE_CAPTURE
        |=> cmpa_reg[7:0] == $past(byte_buf_reg))
        else $error("Buffered low byte not committed.");
    cap_off_a: assert property (mode == stm_pkg::STM_MODE_CAPTURE
        && pin_fn == stm_pkg::PIN_CODE_3 && !wr_cmpa_hi |=> $stable(cmpa_reg))
        else $error("Capture fired while disabled.");
    force_off_a: assert property (mode == stm_pkg::STM_MODE_PWM
        && pin_fn == stm_pkg::PIN_CODE_0
        |=> timer_output_pin_out == (!$past(init_level) ^ $past(polarity)))
        else $error("Forced inactive level not driven.");
    single_stop_a: assert property (single_end && !wr_ctl0 |=> !on_bit)
        else $error("Single pulse did not stop.");
    cmp_drive_a: assert property (mode == stm_pkg::STM_MODE_COMPARE
        |=> timer_output_pin_oe_out)
        else $error("Compare mode pin not driven.");
    pol_invert_a: assert property (mode == stm_pkg::STM_MODE_COMPARE
        |=> timer_output_pin_out == ($past(level_reg) ^ $past(polarity)))
        else $error("Compare pin polarity wrong.");
endmodule
`default_nettype wire

// >>> core/stm_pkg.sv
package stm_pkg;
    localparam logic [2:0] ADDR_CTL0 = 3'h0;
    localparam logic [2:0] ADDR_CTL1 = 3'h1;
    localparam logic [2:0] ADDR_CNT_LO = 3'h2;
    localparam logic [2:0] ADDR_CNT_HI = 3'h3;
    localparam logic [2:0] ADDR_CMPA_LO = 3'h4;
    localparam logic [2:0] ADDR_CMPA_HI = 3'h5;
    localparam logic [2:0] ADDR_CMPP = 3'h6;
    localparam logic [2:0] ADDR_FLAGS = 3'h7;
    localparam int PAUSE_BIT = 7;
    localparam int CLKSEL_MSB = 6;
    localparam int CLKSEL_LSB = 4;
    localparam int ON_BIT = 3;
    localparam int MODE_MSB = 7;
    localparam int MODE_LSB = 6;
    localparam int PINFN_MSB = 5;
    localparam int PINFN_LSB = 4;
    localparam int INIT_LEVEL_BIT = 3;
    localparam int POLARITY_BIT = 2;
    localparam int SWAP_BIT = 1;
    localparam int CLEAR_SEL_BIT = 0;
    localparam int FLAG_A_BIT = 0;
    localparam int FLAG_P_BIT = 1;
    localparam logic [7:0] CTL0_WRITE_MASK = 8'hf8;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [15:0] WORD_ONE = 16'h0001;
    localparam logic [16:0] FULL_PERIOD = 17'h10000;
    localparam logic [5:0] DIV4_MASK = 6'h03;
    localparam logic [5:0] DIV8_MASK = 6'h07;
    localparam logic [5:0] DIV16_MASK = 6'h0f;
    localparam logic [5:0] DIV64_MASK = 6'h3f;
    typedef enum logic [1:0] {
        STM_MODE_COMPARE = 2'b00,
        STM_MODE_CAPTURE = 2'b01,
        STM_MODE_PWM = 2'b10,
        STM_MODE_TIMER = 2'b11
    } stm_mode_e;
    localparam logic [1:0] PIN_CODE_0 = 2'b00;
    localparam logic [1:0] PIN_CODE_1 = 2'b01;
    localparam logic [1:0] PIN_CODE_2 = 2'b10;
    localparam logic [1:0] PIN_CODE_3 = 2'b11;
    typedef enum logic [2:0] {
        STM_CLK_SYS_DIV4 = 3'b000,
        STM_CLK_SYS = 3'b001,
        STM_CLK_HIGH_DIV16 = 3'b010,
        STM_CLK_HIGH_DIV64 = 3'b011,
        STM_CLK_SUB = 3'b100,
        STM_CLK_HIGH_DIV8 = 3'b101,
        STM_CLK_PIN_RISE = 3'b110,
        STM_CLK_PIN_FALL = 3'b111
    } stm_clk_e;
endpackage

// >>> verif/stm_testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic ref_clk_in;
    logic sys_rst_in;
    logic [2:0] reg_addr_in;
    logic [7:0] reg_wr_data_in;
    logic reg_wr_in;
    logic reg_rd_in;
    logic [7:0] reg_rd_data_out;
    logic gen_pin;
    logic [2:0] gen_div;
    logic capture_input_pin_in;
    logic timer_output_pin_out;
    logic timer_output_pin_oe_out;
    logic compare_a_flag_out;
    logic compare_p_flag_out;
    int fail_count;
    int n_checks;

    stm_timer u_dut (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .reg_addr_in(reg_addr_in),
        .reg_wr_data_in(reg_wr_data_in),
        .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in),
        .reg_rd_data_out(reg_rd_data_out),
        .external_count_pin_in(gen_pin),
        .sub_clock_in(gen_pin),
        .capture_input_pin_in(capture_input_pin_in),
        .timer_output_pin_out(timer_output_pin_out),
        .timer_output_pin_oe_out(timer_output_pin_oe_out),
        .compare_a_flag_out(compare_a_flag_out),
        .compare_p_flag_out(compare_p_flag_out)
    );

    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    // Slow pin clock of period ten cycles for the sub clock and external count sources.
    always @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            gen_div <= 3'h0;
            gen_pin <= 1'b0;
        end else if (gen_div == 3'h4) begin
            gen_div <= 3'h0;
            gen_pin <= ~gen_pin;
        end else begin
            gen_div <= gen_div + 3'h1;
        end
    end

    task automatic report_and_stop;
        if (fail_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input logic [15:0] got, input int lo, input int hi);
        n_checks++;
        if ($isunknown(got) || got < lo || got > hi) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_wr_data_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b0;
        #1;
        d = reg_rd_data_out;
    endtask

    task automatic rd_cnt(output logic [15:0] c);
        logic [7:0] hi;
        logic [7:0] lo;
        rd(3'h3, hi);
        rd(3'h2, lo);
        c = {hi, lo};
    endtask

    // Switched off before mode or pin function changes.
    task automatic start(input logic [7:0] c1, input logic [7:0] c0);
        wr(3'h0, 8'h00);
        wr(3'h1, c1);
        wr(3'h7, 8'h03);
        wr(3'h0, c0);
    endtask

    task automatic wait_a(input int lim);
        for (int i = 0; i < lim; i++) begin
            cyc(1);
            if (compare_a_flag_out === 1'b1) begin
                return;
            end
        end
        fail_count++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        report_and_stop();
    endtask

    initial begin
        logic [7:0] d;
        logic [15:0] c;
        logic [15:0] c2;
        logic [1:0] fn;
        logic lvl;
        logic pol;
        logic ex;
        int hi;
        int divs [8] = '{4, 1, 16, 64, 10, 8, 10, 10};
        logic [7:0] pc1 [4] = '{8'ha9, 8'haa, 8'ha8, 8'hac};
        logic [7:0] pah [4] = '{8'h00, 8'h02, 8'h02, 8'h00};
        logic [7:0] pal [4] = '{8'h40, 8'h00, 8'h00, 8'h40};
        int pex [4] = '{128, 256, 512, 384};
        fail_count = 0;
        n_checks = 0;
        sys_rst_in = 1'b1;
        reg_addr_in = 3'h0;
        reg_wr_data_in = 8'h00;
        reg_wr_in = 1'b0;
        reg_rd_in = 1'b0;
        capture_input_pin_in = 1'b0;
        repeat (2) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        for (int a = 0; a < 8; a++) begin
            rd(a[2:0], d);
            chk(16'(d), 16'h0000);
        end
        wr(3'h0, 8'h87);
        rd(3'h0, d);
        chk(16'(d), 16'h0080);
        wr(3'h0, 8'h00);
        wr(3'h2, 8'hff);
        wr(3'h3, 8'hff);
        rd_cnt(c);
        chk(c, 16'h0000);
        wr(3'h4, 8'h34);
        wr(3'h5, 8'h12);
        rd(3'h5, d);
        chk(16'(d), 16'h0012);
        rd(3'h4, d);
        chk(16'(d), 16'h0034);
        wr(3'h4, 8'h56);
        rd(3'h5, d);
        rd(3'h4, d);
        chk(16'(d), 16'h0034);
        wr(3'h6, 8'h00);
        for (int s = 0; s < 8; s++) begin
            start(8'hc0, {1'b0, s[2:0], 4'h8});
            cyc(640);
            wr(3'h0, {1'b0, s[2:0], 4'h0});
            rd_cnt(c);
            chk_rng(c, 640 / divs[s] - 3, 640 / divs[s] + 3);
            chk(16'(timer_output_pin_oe_out), 16'h0000);
            cyc(20);
            rd_cnt(c2);
            chk(c2, c);
        end
        start(8'hc0, 8'h18);
        cyc(50);
        wr(3'h0, 8'h98);
        rd_cnt(c);
        cyc(30);
        rd_cnt(c2);
        chk(c2, c);
        wr(3'h0, 8'h18);
        cyc(30);
        rd_cnt(c2);
        chk_rng(c2, c + 28, c + 38);
        wr(3'h4, 8'h14);
        wr(3'h5, 8'h00);
        wr(3'h6, 8'h01);
        rd(3'h6, d);
        chk(16'(d), 16'h0001);
        for (int i = 0; i < 16; i++) begin
            fn = i[1:0];
            lvl = i[2];
            pol = i[3];
            start({2'b00, fn, lvl, pol, 2'b01}, 8'h18);
            cyc(3);
            chk({15'h0, timer_output_pin_out}, {15'h0, lvl ^ pol});
            chk(16'(timer_output_pin_oe_out), 16'h0001);
            wait_a(60);
            cyc(2);
            ex = (fn == 2'b00) ? lvl : (fn == 2'b01) ? 1'b0 : (fn == 2'b10) ? 1'b1 : ~lvl;
            chk({15'h0, timer_output_pin_out}, {15'h0, ex ^ pol});
        end
        wr(3'h4, 8'h00);
        wr(3'h5, 8'h02);
        start(8'h01, 8'h18);
        cyc(600);
        chk({14'h0, compare_p_flag_out, compare_a_flag_out}, 16'h0001);
        rd(3'h7, d);
        chk(16'(d), 16'h0001);
        start(8'h00, 8'h18);
        cyc(600);
        chk({14'h0, compare_p_flag_out, compare_a_flag_out}, 16'h0002);
        start(8'h88, 8'h18);
        cyc(3);
        chk({15'h0, timer_output_pin_out}, 16'h0000);
        start(8'h98, 8'h18);
        cyc(3);
        chk({15'h0, timer_output_pin_out}, 16'h0001);
        for (int k = 0; k < 4; k++) begin
            wr(3'h4, pal[k]);
            wr(3'h5, pah[k]);
            start(pc1[k], 8'h18);
            cyc(4);
            hi = 0;
            for (int j = 0; j < 512; j++) begin
                cyc(1);
                if (timer_output_pin_out === 1'b1) begin
                    hi++;
                end
            end
            chk_rng(16'(hi), pex[k] - 4, pex[k] + 4);
        end
        wr(3'h4, 8'h40);
        wr(3'h5, 8'h00);
        start(8'hb8, 8'h18);
        cyc(3);
        chk({15'h0, timer_output_pin_out}, 16'h0001);
        wait_a(100);
        cyc(3);
        chk({15'h0, timer_output_pin_out}, 16'h0000);
        rd(3'h0, d);
        chk(16'(d), 16'h0010);
        for (int f = 0; f < 4; f++) begin
            start({2'b01, f[1:0], 4'h0}, 8'h18);
            @(posedge ref_clk_in);
            capture_input_pin_in <= 1'b1;
            cyc(6);
            chk({15'h0, compare_a_flag_out}, {15'h0, f == 0 || f == 2});
            wr(3'h7, 8'h03);
            @(posedge ref_clk_in);
            capture_input_pin_in <= 1'b0;
            cyc(6);
            chk({15'h0, compare_a_flag_out}, {15'h0, f == 1 || f == 2});
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
